//--- include/wsof_buf_if.sv
`timescale 1ns/1ps
interface wsof_buf_if #(parameter int AW = 10);
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic          wr_q;
  logic [15:0]   wr_data;
  logic [AW-1:0] rd_addr;
  logic [15:0]   rd_i;
  logic [15:0]   rd_q;
  modport ctrl (output wr_en, wr_addr, wr_q, wr_data, rd_addr, input rd_i, rd_q);
  modport mem  (input wr_en, wr_addr, wr_q, wr_data, rd_addr, output rd_i, rd_q);
endinterface

//--- include/wsof_pkg.sv
package wsof_pkg;
  // Register offsets (word addresses on the plain port)
  localparam logic [3:0] ADDR_CTRL      = 4'h0;
  localparam logic [3:0] ADDR_IDLE      = 4'h1;
  localparam logic [3:0] ADDR_SEG_START = 4'h2;
  localparam logic [3:0] ADDR_SEG_LEN   = 4'h3;
  localparam logic [3:0] ADDR_STATUS    = 4'h4;
  localparam logic [3:0] ADDR_MARK_OVR  = 4'h5;
  localparam logic [3:0] ADDR_MARK_CMD  = 4'h6;
  // CTRL field positions
  localparam int CTRL_PLAY    = 0;
  localparam int CTRL_INV_I   = 1;
  localparam int CTRL_INV_Q   = 2;
  localparam int CTRL_GRES16  = 3;
  localparam int CTRL_OWID_LO = 8;
  localparam int CTRL_OWID_HI = 12;
  // Reset and code values
  localparam logic [15:0] IDLE_RESET = 16'h8000;
  localparam logic [15:0] CODE_MIN   = 16'h0300;
  localparam logic [15:0] CODE_MAX   = 16'hFD00;
  localparam logic [4:0]  OWID_MIN   = 5'h08;
  localparam logic [4:0]  OWID_MAX   = 5'h10;
  localparam logic [4:0]  OWID_GRES_LOW = 5'h0E;
  localparam int          BYTES_PER_PAIR = 4;
  typedef enum logic [2:0] {
    WSOF_IDLE = 3'b001,
    WSOF_LO   = 3'b010,
    WSOF_HI   = 3'b100
  } wsof_load_t;
endpackage

//--- logic/wsof_buffer.sv
`timescale 1ns/1ps
module wsof_buffer
  import wsof_pkg::*;
#(
  parameter int AW = 10
)
(
  // Clock
  input  wire logic i_clock,
  // Buffer port
  wsof_buf_if.mem   bus
);
  logic [15:0] mem_i [2**AW];
  logic [15:0] mem_q [2**AW];

  // Later writes overwrite earlier ones at the same pair address
  always_ff @(posedge i_clock)
  begin
    if (bus.wr_en && !bus.wr_q)
      mem_i[bus.wr_addr] <= bus.wr_data;
    if (bus.wr_en && bus.wr_q)
      mem_q[bus.wr_addr] <= bus.wr_data;
  end

  // Whole pair read in one cycle
  always_ff @(posedge i_clock)
  begin
    bus.rd_i <= mem_i[bus.rd_addr];
    bus.rd_q <= mem_q[bus.rd_addr];
  end
endmodule

//--- logic/wsof_formatter.sv
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
// Operation
// - Blocks store from their given start address
// - Words alternate I then Q, I first
// - Sixteen-bit words arrive low byte first
// - Two low bits are markers unless full-width
// - Overlapping loads: last written data wins
// - Codes pass to converter unchanged
// - Inverted mode reverses polarity, same magnitude
// - Idle value driven while waiting or stopped
// - Idle value changes only on an idle register write
// - Reset sets both idle values mid-scale
// - Markers work at 14-bit resolution
// - At 16 bits d0 d1 are amplitude
// - At 16 bits marker lists/commands refused
// - Converter takes d2 through d15 always
// - Output width 8..16, not above resolution
// - Narrow width rounds, zeroes unused low bits
// - Reduced value is MSB-justified everywhere
// - Segment start/length counted in I/Q pairs
// - Later marker list overrides embedded bits
module wsof_formatter
  import wsof_pkg::*;
#(
  parameter int AW = 10
)
(
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_sys_rst,
  // Register port
  input  wire logic [3:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic [31:0]      o_reg_rdata,
  // Sample byte loader
  input  wire logic        i_blk_start,
  input  wire logic [AW:0] i_blk_addr,
  input  wire logic        i_byte_valid,
  input  wire logic [7:0]  i_byte,
  // Trigger / run state
  input  wire logic        i_running,
  // Converter and digital outputs
  output logic [13:0]      o_dac_i,
  output logic [13:0]      o_dac_q,
  output logic [15:0]      o_dig_i,
  output logic [15:0]      o_dig_q,
  output logic [3:0]       o_marker,
  output logic             o_out_valid
);
  // Refuse pair address widths the buffer and loader cannot serve
  if (AW < 2 || AW > 20)
  begin : g_bad_aw
    $error("AW out of range");
  end

  wsof_buf_if #(.AW(AW)) buf_bus ();

  wsof_buffer #(.AW(AW)) u_buf (
    .i_clock (i_clock),
    .bus     (buf_bus)
  );

  // Control registers
  logic        play_reg;
  logic        inv_i_reg;
  logic        inv_q_reg;
  logic        gres16_reg;
  logic [4:0]  owid_reg;
  logic [15:0] idle_i_reg;
  logic [15:0] idle_q_reg;
  logic [AW-1:0] seg_start_reg;
  logic [AW-1:0] seg_len_reg;
  logic [3:0]  mark_ovr_reg;
  logic [3:0]  mark_ovr_en_reg;
  logic        mark_rej_reg;
  logic [4:0]  owid_next;
  logic        wr_ctrl;
  logic        wr_mark;

  assign wr_ctrl = i_reg_wr && (i_reg_addr == ADDR_CTRL);
  assign wr_mark = i_reg_wr && (i_reg_addr == ADDR_MARK_OVR || i_reg_addr == ADDR_MARK_CMD);

  // Requested width clamped to 8..16 and to the generation resolution
  always_comb
  begin
    owid_next = i_reg_wdata[CTRL_OWID_HI:CTRL_OWID_LO];
    if (owid_next < OWID_MIN)
      owid_next = OWID_MIN;
    if (owid_next > OWID_MAX)
      owid_next = OWID_MAX;
    if (!i_reg_wdata[CTRL_GRES16] && owid_next > OWID_GRES_LOW)
      owid_next = OWID_GRES_LOW;
  end

  // Control word
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      play_reg   <= 1'b0;
      inv_i_reg  <= 1'b0;
      inv_q_reg  <= 1'b0;
      gres16_reg <= 1'b0;
      owid_reg   <= OWID_GRES_LOW;
    end
    else if (wr_ctrl)
    begin
      play_reg   <= i_reg_wdata[CTRL_PLAY];
      inv_i_reg  <= i_reg_wdata[CTRL_INV_I];
      inv_q_reg  <= i_reg_wdata[CTRL_INV_Q];
      gres16_reg <= i_reg_wdata[CTRL_GRES16];
      owid_reg   <= owid_next;
    end
  end

  // Idle values: only an explicit idle write changes them
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      idle_i_reg <= IDLE_RESET;
      idle_q_reg <= IDLE_RESET;
    end
    else if (i_reg_wr && i_reg_addr == ADDR_IDLE)
    begin
      idle_i_reg <= i_reg_wdata[15:0];
      idle_q_reg <= i_reg_wdata[31:16];
    end
  end

  // Segment window, in I/Q pairs
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      seg_start_reg <= '0;
      seg_len_reg   <= '0;
    end
    else if (i_reg_wr && i_reg_addr == ADDR_SEG_START)
      seg_start_reg <= i_reg_wdata[AW-1:0];
    else if (i_reg_wr && i_reg_addr == ADDR_SEG_LEN)
      seg_len_reg <= i_reg_wdata[AW-1:0];
  end

  // Marker list override; refused and cleared at 16-bit resolution
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      mark_ovr_reg    <= 4'h0;
      mark_ovr_en_reg <= 4'h0;
      mark_rej_reg    <= 1'b0;
    end
    else if (gres16_reg)
    begin
      mark_ovr_en_reg <= 4'h0;
      if (wr_mark)
        mark_rej_reg <= 1'b1;
      else if (i_reg_wr && i_reg_addr == ADDR_STATUS && i_reg_wdata[1])
        mark_rej_reg <= 1'b0;
    end
    else if (i_reg_wr && i_reg_addr == ADDR_MARK_OVR)
    begin
      mark_ovr_reg    <= i_reg_wdata[3:0];
      mark_ovr_en_reg <= i_reg_wdata[7:4];
    end
    else if (i_reg_wr && i_reg_addr == ADDR_STATUS && i_reg_wdata[1])
      mark_rej_reg <= 1'b0;
  end

  // Byte loader
  wsof_load_t    ld_state;
  logic [7:0]    lo_byte_reg;
  logic [AW:0]   wptr_reg;
  logic          wr_en_reg;
  logic [15:0]   wr_data_reg;
  logic [AW:0]   wr_word_reg;
  logic          load_err_reg;

  // Assemble words low byte first and store from the block address
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      ld_state    <= WSOF_IDLE;
      lo_byte_reg <= 8'h00;
      wptr_reg    <= '0;
      wr_en_reg   <= 1'b0;
      wr_data_reg <= 16'h0000;
      wr_word_reg <= '0;
    end
    else
    begin
      wr_en_reg <= 1'b0;
      case (ld_state)
        WSOF_IDLE:
        begin
          if (i_blk_start)
          begin
            wptr_reg <= {i_blk_addr[AW-1:0], 1'b0};
            ld_state <= WSOF_LO;
          end
        end
        WSOF_LO:
        begin
          if (i_blk_start)
            wptr_reg <= {i_blk_addr[AW-1:0], 1'b0};
          else if (i_byte_valid)
          begin
            lo_byte_reg <= i_byte;
            ld_state    <= WSOF_HI;
          end
        end
        WSOF_HI:
        begin
          if (i_blk_start)
          begin
            wptr_reg <= {i_blk_addr[AW-1:0], 1'b0};
            ld_state <= WSOF_LO;
          end
          else if (i_byte_valid)
          begin
            wr_data_reg <= {i_byte, lo_byte_reg};
            wr_word_reg <= wptr_reg;
            wr_en_reg   <= 1'b1;
            wptr_reg    <= wptr_reg + 1'b1;
            ld_state    <= WSOF_LO;
          end
        end
        default:
          ld_state <= WSOF_IDLE;
      endcase
    end
  end

  // A block cut short inside a word is flagged
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
      load_err_reg <= 1'b0;
    else if (ld_state == WSOF_HI && i_blk_start)
      load_err_reg <= 1'b1;
    else if (i_reg_wr && i_reg_addr == ADDR_STATUS && i_reg_wdata[0])
      load_err_reg <= 1'b0;
  end

  assign buf_bus.wr_en   = wr_en_reg;
  assign buf_bus.wr_addr = wr_word_reg[AW:1];
  assign buf_bus.wr_q    = wr_word_reg[0];
  assign buf_bus.wr_data = wr_data_reg;

  // Playback address: ascending, wrapping inside the segment
  logic [AW-1:0] roff_reg;
  logic          play_d_reg;
  logic          active;

  assign active = play_reg && i_running;

  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      roff_reg   <= '0;
      play_d_reg <= 1'b0;
    end
    else
    begin
      play_d_reg <= active;
      if (!active)
        roff_reg <= '0;
      else if (seg_len_reg != '0 && roff_reg == seg_len_reg - 1'b1)
        roff_reg <= '0;
      else
        roff_reg <= roff_reg + 1'b1;
    end
  end

  assign buf_bus.rd_addr = seg_start_reg + roff_reg;

  // Sample formatting
  logic [15:0] amp_i;
  logic [15:0] amp_q;
  logic [15:0] full_i;
  logic [15:0] full_q;
  logic [13:0] dac_i;
  logic [13:0] dac_q;
  logic [3:0]  mark_raw;
  logic [3:0]  mark_sel;

  // Markers stripped from d0/d1 except at 16-bit resolution
  always_comb
  begin
    if (gres16_reg)
    begin
      amp_i    = buf_bus.rd_i;
      amp_q    = buf_bus.rd_q;
      mark_raw = 4'h0;
    end
    else
    begin
      amp_i    = {buf_bus.rd_i[15:2], 2'b00};
      amp_q    = {buf_bus.rd_q[15:2], 2'b00};
      mark_raw = {buf_bus.rd_q[1:0], buf_bus.rd_i[1:0]};
    end
    mark_sel = (mark_raw & ~mark_ovr_en_reg) | (mark_ovr_reg & mark_ovr_en_reg);
  end

  // Stored code passed on without arithmetic apart from width and mode
  wsof_reduce u_red_i (
    .i_sample (play_d_reg ? amp_i : idle_i_reg),
    .i_width  (owid_reg),
    .i_invert (inv_i_reg),
    .o_full   (full_i),
    .o_dac    (dac_i)
  );

  wsof_reduce u_red_q (
    .i_sample (play_d_reg ? amp_q : idle_q_reg),
    .i_width  (owid_reg),
    .i_invert (inv_q_reg),
    .o_full   (full_q),
    .o_dac    (dac_q)
  );

  // Outputs registered together so amplitude and markers align
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      o_dac_i     <= IDLE_RESET[15:2];
      o_dac_q     <= IDLE_RESET[15:2];
      o_dig_i     <= IDLE_RESET;
      o_dig_q     <= IDLE_RESET;
      o_marker    <= 4'h0;
      o_out_valid <= 1'b0;
    end
    else
    begin
      o_dac_i     <= dac_i;
      o_dac_q     <= dac_q;
      o_dig_i     <= full_i;
      o_dig_q     <= full_q;
      o_marker    <= (play_d_reg && !gres16_reg) ? mark_sel : 4'h0;
      o_out_valid <= play_d_reg;
    end
  end

  // Register read, data valid one cycle after the strobe, zero otherwise
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst || !i_reg_rd)
      o_reg_rdata <= 32'h0000_0000;
    else
      case (i_reg_addr)
        ADDR_CTRL:      o_reg_rdata <= {19'h0, owid_reg, 4'h0, gres16_reg, inv_q_reg,
                                        inv_i_reg, play_reg};
        ADDR_IDLE:      o_reg_rdata <= {idle_q_reg, idle_i_reg};
        ADDR_SEG_START: o_reg_rdata <= 32'(seg_start_reg);
        ADDR_SEG_LEN:   o_reg_rdata <= 32'(seg_len_reg);
        ADDR_STATUS:    o_reg_rdata <= {29'h0, play_d_reg, mark_rej_reg, load_err_reg};
        ADDR_MARK_OVR:  o_reg_rdata <= {24'h0, mark_ovr_en_reg, mark_ovr_reg};
        default:        o_reg_rdata <= 32'h0000_0000;
      endcase
  end
endmodule

//--- logic/wsof_reduce.sv
`timescale 1ns/1ps
module wsof_reduce
  import wsof_pkg::*;
(
  // Sample in
  input  wire logic [15:0] i_sample,
  input  wire logic [4:0]  i_width,
  input  wire logic        i_invert,
  // Result
  output logic [15:0]      o_full,
  output logic [13:0]      o_dac
);
  logic [16:0] rounded;
  logic [15:0] mask;
  logic [15:0] half;
  logic [15:0] clipped;
  logic [15:0] inverted_level_mode;

  // Round to width, zero the unused low bits, MSB-justified
  always_comb
  begin
    mask = 16'hFFFF << (5'h10 - i_width);
    half = (i_width >= OWID_MAX) ? 16'h0000 : ((~mask) >> 1) + 16'h0001;
    rounded = {1'b0, i_sample} + {1'b0, half};
    clipped = rounded[16] ? mask : (rounded[15:0] & mask);
    // Mirror about mid-scale for the inverted level mode
    inverted_level_mode = 16'h0000 - clipped;
    o_full = i_invert ? (inverted_level_mode & mask) : clipped;
    o_dac = o_full[15:2];
  end
endmodule

//--- tb/wsof_conv_model.sv
`timescale 1ns/1ps
module wsof_conv_model (
  // Clock
  input  wire logic        i_clock,
  // Formatted samples from the block
  input  wire logic [15:0] i_dig_i,
  input  wire logic [15:0] i_dig_q,
  input  wire logic        i_valid,
  // Last pair taken in
  output logic [15:0]      o_last_i,
  output logic [15:0]      o_last_q
);
  // Take in one pair per clock while samples are valid
  always_ff @(posedge i_clock)
  begin
    if (i_valid)
    begin
      o_last_i <= i_dig_i;
      o_last_q <= i_dig_q;
    end
  end
endmodule

//--- tb/wsof_formatter_properties.sv
`timescale 1ns/1ps
module wsof_formatter_properties
  import wsof_pkg::*;
#(
  parameter int AW = 10
)
(
  // Clock, reset and register port
  input wire logic        i_clock,
  input wire logic        i_sys_rst,
  input wire logic [3:0]  i_reg_addr,
  input wire logic        i_reg_rd,
  input wire logic [31:0] o_reg_rdata,
  // Run state and outputs
  input wire logic        i_running,
  input wire logic [13:0] o_dac_i,
  input wire logic [13:0] o_dac_q,
  input wire logic [15:0] o_dig_i,
  input wire logic [15:0] o_dig_q,
  input wire logic [3:0]  o_marker,
  input wire logic        o_out_valid
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  // Values seen just after reset is released
  property p_rst_out;
    $fell(i_sys_rst) |-> o_dig_i == IDLE_RESET && o_dig_q == IDLE_RESET;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("reset level wrong");
  property p_rst_quiet;
    $fell(i_sys_rst) |-> !o_out_valid && o_marker == 4'h0;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("reset flags wrong");

  // Converter takes the top fourteen bits of the digital value
  property p_dac_msb;
    o_dac_i == o_dig_i[15:2] && o_dac_q == o_dig_q[15:2];
  endproperty
  a_dac_msb: assert property (p_dac_msb) else $error("converter misaligned");

  // Idle and stop behaviour
  sequence s_halt;
    !i_running [*3];
  endsequence
  property p_halt;
    s_halt |=> !o_out_valid;
  endproperty
  a_halt: assert property (p_halt) else $error("valid while stopped");
  property p_idle_mark;
    !o_out_valid |-> o_marker == 4'h0;
  endproperty
  a_idle_mark: assert property (p_idle_mark) else $error("marker while idle");
  property p_run_lag;
    o_out_valid |-> $past(i_running, 2);
  endproperty
  a_run_lag: assert property (p_run_lag) else $error("valid without run");

  // Read data only in the cycle after a read
  property p_rd_quiet;
    !$past(i_reg_rd) |-> o_reg_rdata == 32'h0;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("stray read data");
  property p_unmapped;
    i_reg_rd && i_reg_addr > ADDR_MARK_CMD |=> o_reg_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule

bind wsof_formatter wsof_formatter_properties #(.AW(AW)) u_props (
  .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_reg_addr(i_reg_addr), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata), .i_running(i_running), .o_dac_i(o_dac_i), .o_dac_q(o_dac_q),
  .o_dig_i(o_dig_i), .o_dig_q(o_dig_q), .o_marker(o_marker), .o_out_valid(o_out_valid));

//--- tb/wsof_formatter_test.sv
`timescale 1ns/1ps
module wsof_formatter_test;
  import wsof_pkg::*;
  localparam int AW = 4;
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, bs = 1'b0, bv = 1'b0, run = 1'b0;
  logic [3:0]  ra = 4'h0;
  logic [31:0] wd = 32'h0, rdata, r;
  logic [AW:0] ba = '0;
  logic [7:0]  by = 8'h00;
  logic [13:0] dac_i, dac_q;
  logic [15:0] dig_i, dig_q, last_i, last_q;
  logic [3:0]  mk;
  logic        vld;
  int          fail_count = 0, n_checks = 0, cyc = 0, i;
  logic [15:0] ct [4] = '{16'h0E04, 16'h0804, 16'h100C, 16'h1004};
  logic [15:0] ei [4] = '{16'h12C0, 16'h1300, 16'h12C1, 16'h12C0};
  logic [15:0] ld [6] = '{16'h3001, 16'h5002, 16'h7003, 16'h9000, 16'hA001, 16'hB003};
  logic [15:0] pi [2] = '{16'h3000, 16'hA000};
  logic [15:0] pq [2] = '{16'h5000, 16'hB000};
  logic [3:0]  pm [2] = '{4'h9, 4'hD};

  // Block under test and converter side
  wsof_formatter #(.AW(AW)) dut (.i_clock(clk), .i_sys_rst(rst), .i_reg_addr(ra),
    .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_blk_start(bs),
    .i_blk_addr(ba), .i_byte_valid(bv), .i_byte(by), .i_running(run), .o_dac_i(dac_i),
    .o_dac_q(dac_q), .o_dig_i(dig_i), .o_dig_q(dig_q), .o_marker(mk), .o_out_valid(vld));
  wsof_conv_model far (.i_clock(clk), .i_dig_i(dig_i), .i_dig_q(dig_q), .i_valid(vld),
    .o_last_i(last_i), .o_last_q(last_q));

  // Clock and hang guard
  initial
  begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fail_count++;
      stop_test();
    end
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    ra <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    ra <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  // Low byte first, then high byte
  task automatic word(input logic [15:0] w);
    @(posedge clk);
    bv <= 1'b1;
    by <= w[7:0];
    @(posedge clk);
    by <= w[15:8];
    @(posedge clk);
    bv <= 1'b0;
  endtask
  task automatic blk(input logic [AW:0] a);
    @(posedge clk);
    bs <= 1'b1;
    ba <= a;
    @(posedge clk);
    bs <= 1'b0;
  endtask
  task automatic settle;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic t_reset;
    @(negedge clk);
    chk("dig_q", dig_q, 16'h8000);
    chk("dac_i", dac_i, 14'h2000);
    rreg(ADDR_IDLE, r);
    chk("idle", r, 32'h80008000);
    rreg(4'hF, r);
    chk("unmapped", r, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_idle;
    wreg(ADDR_IDLE, {16'h4000, 16'h12C1});
    for (i = 0; i < 4; i++)
    begin
      wreg(ADDR_CTRL, {16'h0, ct[i]});
      settle();
      chk("idle_i", dig_i, ei[i]);
      chk("idle_q", dig_q, 16'hC000);
    end
    chk("dac_i", dac_i, 14'h04B0);
    wreg(ADDR_CTRL, 32'h0000100C);
    wreg(ADDR_MARK_CMD, 32'h1);
    rreg(ADDR_STATUS, r);
    chk("reject", r[1], 1'b1);
    wreg(ADDR_STATUS, 32'h2);
    rreg(ADDR_STATUS, r);
    chk("reject_clr", r[1], 1'b0);
    wreg(ADDR_CTRL, 32'h00000E00);
    $display("idle test done");
  endtask
  task automatic t_play;
    for (i = 0; i < 6; i++)
    begin
      if (i == 0 || i == 4)
        blk(i == 0 ? 5'h02 : 5'h03);
      word(ld[i]);
    end
    settle();
    chk("idle_kept", dig_i, 16'h12C0);
    // A block cut after its low byte is flagged and then cleared
    blk(5'h01);
    @(posedge clk);
    bv <= 1'b1;
    @(posedge clk);
    bv <= 1'b0;
    blk(5'h01);
    rreg(ADDR_STATUS, r);
    chk("load_err", r[0], 1'b1);
    wreg(ADDR_STATUS, 32'h1);
    rreg(ADDR_STATUS, r);
    chk("err_clr", r[0], 1'b0);
    wreg(ADDR_SEG_START, 32'h2);
    wreg(ADDR_SEG_LEN, 32'h2);
    wreg(ADDR_CTRL, 32'h00000E01);
    run <= 1'b1;
    for (i = 0; i < 20 && vld !== 1'b1; i++)
      @(negedge clk);
    for (i = 0; i < 4; i++)
    begin
      chk("play_i", dig_i, pi[i % 2]);
      chk("play_q", dig_q, pq[i % 2]);
      chk("marker", mk, pm[i % 2]);
      @(negedge clk);
    end
    chk("far_i", last_i, pi[1]);
    wreg(ADDR_MARK_OVR, 32'hF6);
    settle();
    chk("override", mk, 4'h6);
    rreg(ADDR_STATUS, r);
    chk("playing", r[2], 1'b1);
    @(posedge clk);
    run <= 1'b0;
    settle();
    chk("stop_i", dig_i, 16'h12C0);
    // Full 16-bit resolution, I inverted: low bits are amplitude, no markers
    wreg(ADDR_CTRL, 32'h0000100B);
    run <= 1'b1;
    for (i = 0; i < 20 && vld !== 1'b1; i++)
      @(negedge clk);
    chk("g16_i", dig_i, 16'hCFFF);
    chk("g16_q", dig_q, 16'h5002);
    chk("g16_mk", mk, 4'h0);
    chk("g16_dac", dac_i, 14'h33FF);
    $display("play test done");
  endtask

  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_idle();
    t_play();
    stop_test();
  end
endmodule
